//--- buckboost_seq_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BUCKBOOST_SEQ_MAP_SVH
`define BUCKBOOST_SEQ_MAP_SVH
`define BBS_ADDR_W 8
`define BBS_ADDR_CTRL 8'h00
`define BBS_ADDR_STATUS 8'h04
`define BBS_ADDR_EVENTS 8'h08
`define BBS_ADDR_PEAKCAP 8'h0c
`define BBS_CTRL_RUN_BIT 0
`define BBS_CTRL_RESET 1'b1
`define BBS_EVT_OCP_BIT 0
`define BBS_EVT_TSD_BIT 1
`define BBS_EVT_FLT_BIT 2
`define BBS_EVT_W 3
`define BBS_ST_STATE_LSB 0
`define BBS_ST_AUXOFF_BIT 2
`define BBS_ST_NEGLIM_BIT 3
`define BBS_ST_CFGVALID_BIT 4
`define BBS_ST_PIN_BIT 5
`define BBS_ST_CFG_LSB 8
`define BBS_CFG_W 4
`define BBS_CFG_HICCUP_BIT 1
`define BBS_CFG_LIMIT_BIT 2
`define BBS_HICCUP_ON_CYCLES 1024
`define BBS_HICCUP_OFF_CYCLES 4096
`define BBS_DEGLITCH_CYCLES 8
`define BBS_PEAK_W 8
`endif

//--- buckboost_seq_pkg.sv
// Types shared by the start-up and protection sequencer
package buckboost_seq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RAMP,
    ST_RUN,
    ST_HICCUP
  } seq_state_t;
endpackage

//--- pin_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 1
)(
  input wire logic mclk, // Clock
  input wire logic arst_n, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic [WIDTH-1:0] pinIn, // Asynchronous inputs
  output logic [WIDTH-1:0] syncOut // Accepted levels
);
  logic [WIDTH-1:0] stage1Reg;
  logic [WIDTH-1:0] stage2Reg;
  logic [WIDTH-1:0] stage3Reg;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync3: WIDTH must be at least 1");
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stage1Reg <= '0;
      stage2Reg <= '0;
      stage3Reg <= '0;
      syncOut <= '0;
    end else if (ce) begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2Reg[i] == stage3Reg[i]) begin
          syncOut[i] <= stage3Reg[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- fault_deglitch.sv
// Per-source digital de-glitch filter for the fault output
`timescale 1ns/1ps
`default_nettype none
module fault_deglitch #(
  parameter int WIDTH = 1,
  parameter int STABLE_CYCLES = 8
)(
  input wire logic mclk, // Clock
  input wire logic arst_n, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic [WIDTH-1:0] rawIn, // Unfiltered fault sources
  output logic [WIDTH-1:0] cleanOut // Filtered fault sources
);
  localparam int CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  if (STABLE_CYCLES < 1) begin : g_chk
    $error("fault_deglitch: STABLE_CYCLES must be at least 1");
  end

  for (genvar g = 0; g < WIDTH; g++) begin : g_ch
    logic [CW-1:0] cnt_reg;
    // Output flips only after the input held its new level long enough
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_reg <= '0;
        cleanOut[g] <= 1'b0;
      end else if (ce) begin
        if (rawIn[g] == cleanOut[g]) begin
          cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
          cnt_reg <= '0;
          cleanOut[g] <= rawIn[g];
        end else begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- buckboost_startup_protection_seq.sv
// Start-up, soft-start, hiccup and fault sequencing for a buck-boost controller
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "buckboost_seq_map.svh"
// Function
// R1: Ramp starts from zero, sets target
// R2: Ramp above reference switches to internal reference
// R3: Discharge ramp on disable, undervoltage, hiccup, overtemperature
// R4: Latch monitor-tied-to-supply at start, disables amplifier
// R5: Outside never retie monitor pin while running
// R6: Outside holds sync low for negative limit
// R7: Latch limit direction at window end
// R8: Sync high or valid selects positive
// R9: Lower peak limit while aux sense exceeds reference
// R10: Hiccup stops converter after on-time of limiting
// R11: Hiccup discharges ramp, output off for off-time
// R12: After off-time restart through normal soft-start
// R13: Hiccup timing restarts only after ramp finished
// R14: Without hiccup keep cycle-by-cycle limiting
// R15: Pull fault output low on any fault
// R16: Release fault output when fault clears
// R17: De-glitch fault sources, bounded reaction time
// R18: Stop converter above thermal threshold
// R19: Resume through state machine after cooling
// R20: Peak overcurrent raises trip, stops, restarts
// R21: Latch strap at power-up until enable/supply drop
// R22: Hiccup on/off times are parameter counts
module buckboost_startup_protection_seq #(
  parameter int HICCUP_ON_CYCLES = `BBS_HICCUP_ON_CYCLES,
  parameter int HICCUP_OFF_CYCLES = `BBS_HICCUP_OFF_CYCLES,
  parameter int DEGLITCH_CYCLES = `BBS_DEGLITCH_CYCLES,
  parameter int PEAK_W = `BBS_PEAK_W
)(
  input wire logic mclk, // Clock, 250 MHz
  input wire logic arst_n, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write
  input wire logic [`BBS_ADDR_W-1:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic ack_o, // Wishbone acknowledge
  output logic [31:0] dat_o, // Wishbone read data
  input wire logic enableUndervoltageInput, // Enable above threshold
  input wire logic vccOk, // Supply above undervoltage
  input wire logic rampAboveRef, // Ramp comparator above reference
  input wire logic currentMonitorTied, // Monitor pin tied to supply
  input wire logic syncLevel, // External frequency input level
  input wire logic syncValid, // Valid sync clock detected
  input wire logic auxSenseOverRef, // Aux sense above its reference
  input wire logic peakSenseLimit, // Peak sense a-b over limit
  input wire logic overTempHigh, // Die above shutdown threshold
  input wire logic powerGoodFail, // Feedback under power-good level
  input wire logic [`BBS_CFG_W-1:0] cfgStrap, // Configuration strap code
  input wire logic faultOutNIn, // Fault pin level seen
  output logic faultOutNOut, // Fault pin drive value
  output logic faultOutNOe, // Fault pin pull-down enable
  output logic rampCharge, // Ramp current source on
  output logic rampDischarge, // Ramp discharge switch on
  output logic useInternalRef, // Amplifier on internal reference
  output logic converterRun, // Power stage enabled
  output logic auxAmpOff, // Aux amplifier disabled
  output logic negCurrentLimit, // Negative limit direction
  output logic [PEAK_W-1:0] peakCapLevel, // Allowed peak current
  output logic overcurrentTrip, // Pulse on hiccup entry
  output logic overTemperatureStop, // Thermal stop active
  output logic [`BBS_CFG_W-1:0] cfgLatched // Latched strap code
);
  import buckboost_seq_pkg::*;

  localparam int ONW = $clog2(HICCUP_ON_CYCLES + 1);
  localparam int OFFW = $clog2(HICCUP_OFF_CYCLES + 1);
  localparam logic [ONW-1:0] ON_MAX = ONW'(HICCUP_ON_CYCLES);
  localparam logic [OFFW-1:0] OFF_LAST = OFFW'(HICCUP_OFF_CYCLES - 1);
  localparam logic [PEAK_W-1:0] PEAK_MAX = '1;
  localparam int NSYNC = 11 + `BBS_CFG_W;
  localparam int FAULT_OUTPUT_N = 3;

  if (HICCUP_ON_CYCLES < 1 || HICCUP_OFF_CYCLES < 1 || PEAK_W < 2) begin : g_chk
    $error("buckboost_startup_protection_seq: bad parameter value");
  end

  logic [NSYNC-1:0] syncBus;
  logic enS, vccS, rampS, monTiedS, syncS, syncValidS;
  logic auxOverS, peakS, hotS, pgFailS, pinS;
  logic [`BBS_CFG_W-1:0] strapS;
  seq_state_t state_reg, state_next;
  logic window_reg, sawHigh_reg, cfgValid_reg, runCtrl_reg;
  logic [ONW-1:0] onCnt_reg;
  logic [OFFW-1:0] offCnt_reg;
  logic [`BBS_EVT_W-1:0] events_reg;
  logic [FAULT_OUTPUT_N-1:0] faultRaw, faultClean;
  logic runOk, startGo, hiccupEn, limitMode, hiccupGo, wbReq, wbWrite;
  logic stopping, syncHighSeen;
  logic [`BBS_EVT_W-1:0] evtSet, evtClr;

  pin_sync3 #(.WIDTH(NSYNC)) u_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .pinIn({faultOutNIn, cfgStrap, powerGoodFail, overTempHigh,
            peakSenseLimit, auxSenseOverRef, syncValid, syncLevel,
            currentMonitorTied, rampAboveRef, vccOk,
            enableUndervoltageInput}),
    .syncOut(syncBus)
  );
  assign {pinS, strapS, pgFailS, hotS, peakS, auxOverS, syncValidS, syncS,
          monTiedS, rampS, vccS, enS} = syncBus;

  assign runOk = enS && vccS && !hotS && runCtrl_reg;
  assign startGo = (state_reg == ST_IDLE) && runOk && window_reg;
  assign syncHighSeen = sawHigh_reg || syncS || syncValidS;
  assign hiccupEn = cfgLatched[`BBS_CFG_HICCUP_BIT];
  assign limitMode = cfgLatched[`BBS_CFG_LIMIT_BIT];
  // R10 R14: limiting past on-time, only with hiccup on
  assign hiccupGo = hiccupEn && peakS && (onCnt_reg == ON_MAX);
  assign stopping = !runOk;
  assign wbReq = cyc_i && stb_i;
  assign wbWrite = wbReq && we_i && ack_o;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (startGo) begin
          state_next = ST_RAMP;
        end
      end
      ST_RAMP: begin
        // R3: any disable drops back and discharges
        if (stopping) begin
          state_next = ST_IDLE;
        // R2: ramp past reference ends soft-start
        end else if (rampS) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // R18: thermal trip is one of the stop causes
        if (stopping) begin
          state_next = ST_IDLE;
        // R20: overcurrent stops the converter
        end else if (hiccupGo) begin
          state_next = ST_HICCUP;
        end
      end
      ST_HICCUP: begin
        if (stopping) begin
          state_next = ST_IDLE;
        // R12: off-time over, normal soft-start again
        end else if (offCnt_reg == OFF_LAST) begin
          state_next = ST_RAMP;
        end
      end
    endcase
  end

  // R19: cooling lets the state machine restart
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // R1: ramp charges from discharged zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rampCharge <= 1'b0;
      rampDischarge <= 1'b1;
      useInternalRef <= 1'b0;
      converterRun <= 1'b0;
      overTemperatureStop <= 1'b0;
      overcurrentTrip <= 1'b0;
    end else if (ce) begin
      rampCharge <= (state_next == ST_RAMP);
      // R11: hiccup keeps ramp discharged, output off
      rampDischarge <= (state_next == ST_IDLE) || (state_next == ST_HICCUP);
      useInternalRef <= (state_next == ST_RUN);
      converterRun <= (state_next == ST_RAMP) || (state_next == ST_RUN);
      overTemperatureStop <= hotS;
      overcurrentTrip <= (state_reg == ST_RUN) && (state_next == ST_HICCUP);
    end
  end

  // R13: on-time counts only once the ramp finished
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      onCnt_reg <= '0;
    end else if (ce) begin
      if (state_next != ST_RUN || !peakS) begin
        onCnt_reg <= '0;
      end else if (onCnt_reg != ON_MAX) begin
        onCnt_reg <= onCnt_reg + ONW'(1);
      end
    end
  end

  // R22: off-time counter starts as converter stops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      offCnt_reg <= '0;
    end else if (ce) begin
      if (state_reg != ST_HICCUP) begin
        offCnt_reg <= '0;
      end else begin
        offCnt_reg <= offCnt_reg + OFFW'(1);
      end
    end
  end

  // R6: window runs from enable until ramp start
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      window_reg <= 1'b0;
      sawHigh_reg <= 1'b0;
    end else if (ce) begin
      if (state_reg == ST_IDLE && runOk && !startGo) begin
        window_reg <= 1'b1;
        sawHigh_reg <= syncHighSeen;
      end else begin
        window_reg <= 1'b0;
        sawHigh_reg <= 1'b0;
      end
    end
  end

  // R7: direction and monitor choice latched at window end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      negCurrentLimit <= 1'b0;
      auxAmpOff <= 1'b0;
    end else if (ce && startGo) begin
      // R8: any high or valid sync picks positive
      negCurrentLimit <= !syncHighSeen;
      // R4: monitor tied to supply disables amplifier
      auxAmpOff <= monTiedS;
    end
  end

  // R21: strap held until enable or supply falls
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfgValid_reg <= 1'b0;
      cfgLatched <= '0;
    end else if (ce) begin
      if (!enS || !vccS) begin
        cfgValid_reg <= 1'b0;
      end else if (!cfgValid_reg) begin
        cfgValid_reg <= 1'b1;
        cfgLatched <= strapS;
      end
    end
  end

  // R9: step peak limit down while aux sense is over
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      peakCapLevel <= PEAK_MAX;
    end else if (ce) begin
      if (!limitMode || auxAmpOff || state_reg != ST_RUN) begin
        peakCapLevel <= PEAK_MAX;
      end else if (auxOverS && peakCapLevel != '0) begin
        peakCapLevel <= peakCapLevel - PEAK_W'(1);
      end else if (!auxOverS && peakCapLevel != PEAK_MAX) begin
        peakCapLevel <= peakCapLevel + PEAK_W'(1);
      end
    end
  end

  // Power-good is masked during soft-start
  assign faultRaw = {pgFailS && (state_reg == ST_RUN), hotS,
                     state_reg == ST_HICCUP};

  // R17: each fault source passes its own filter
  fault_deglitch #(.WIDTH(FAULT_OUTPUT_N), .STABLE_CYCLES(DEGLITCH_CYCLES)) u_dgl (
    .mclk(mclk),
    .arst_n(arst_n),
    .ce(ce),
    .rawIn(faultRaw),
    .cleanOut(faultClean)
  );

  // R15: any filtered fault pulls the pin low
  // R16: released once all filtered faults clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      faultOutNOe <= 1'b0;
      faultOutNOut <= 1'b0;
    end else if (ce) begin
      faultOutNOe <= |faultClean;
      faultOutNOut <= 1'b0;
    end
  end

  // Software run enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      runCtrl_reg <= `BBS_CTRL_RESET;
    end else if (ce && wbWrite && adr_i == `BBS_ADDR_CTRL && sel_i[0]) begin
      runCtrl_reg <= dat_i[`BBS_CTRL_RUN_BIT];
    end
  end

  // Sticky events, write one to clear, set wins
  always_comb begin
    evtClr = '0;
    if (wbWrite && adr_i == `BBS_ADDR_EVENTS && sel_i[0]) begin
      evtClr = dat_i[`BBS_EVT_W-1:0];
    end
    evtSet = '0;
    evtSet[`BBS_EVT_OCP_BIT] = (state_reg == ST_RUN) && hiccupGo && runOk;
    evtSet[`BBS_EVT_TSD_BIT] = hotS;
    evtSet[`BBS_EVT_FLT_BIT] = |faultClean;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      events_reg <= '0;
    end else if (ce) begin
      events_reg <= (events_reg & ~evtClr) | evtSet;
    end
  end

  // Bus answer one cycle after request, unmapped reads zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else if (ce) begin
      ack_o <= wbReq && !ack_o;
      if (wbReq && !ack_o) begin
        dat_o <= '0;
        unique case (adr_i)
          `BBS_ADDR_CTRL: dat_o[`BBS_CTRL_RUN_BIT] <= runCtrl_reg;
          `BBS_ADDR_STATUS: begin
            dat_o[`BBS_ST_STATE_LSB+:2] <= state_reg;
            dat_o[`BBS_ST_AUXOFF_BIT] <= auxAmpOff;
            dat_o[`BBS_ST_NEGLIM_BIT] <= negCurrentLimit;
            dat_o[`BBS_ST_CFGVALID_BIT] <= cfgValid_reg;
            dat_o[`BBS_ST_PIN_BIT] <= pinS;
            dat_o[`BBS_ST_CFG_LSB+:`BBS_CFG_W] <= cfgLatched;
          end
          `BBS_ADDR_EVENTS: dat_o[`BBS_EVT_W-1:0] <= events_reg;
          `BBS_ADDR_PEAKCAP: dat_o[PEAK_W-1:0] <= peakCapLevel;
          default: dat_o <= '0;
        endcase
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n || !ce);

  sequence s_hiccup_done;
    state_reg == ST_HICCUP && offCnt_reg == OFF_LAST && runOk;
  endsequence
  sequence s_restart;
    state_reg == ST_RAMP ##0 rampCharge && !rampDischarge;
  endsequence

  a_ramp_from_zero: assert property ( // R1
    $rose(state_reg == ST_RAMP) |-> rampCharge && !useInternalRef)
    else $error("ramp not charging at soft-start begin");
  a_ref_switch: assert property ( // R2
    state_reg == ST_RAMP && rampS && runOk |=> state_reg == ST_RUN
      && useInternalRef)
    else $error("reference not switched after ramp");
  a_discharge_stop: assert property ( // R3
    !runOk |=> ##1 rampDischarge && !converterRun)
    else $error("ramp not discharged on disable");
  a_aux_choice_held: assert property ( // R4
    state_reg != ST_IDLE && $past(state_reg) != ST_IDLE |-> $stable(auxAmpOff))
    else $error("aux amplifier choice changed while running");
  a_dir_positive: assert property ( // R8
    startGo && syncHighSeen |=> !negCurrentLimit)
    else $error("positive limit not selected");
  a_dir_latched: assert property ( // R7
    state_reg == ST_RUN && $past(state_reg) == ST_RUN
      |-> $stable(negCurrentLimit))
    else $error("limit direction changed after window");
  a_peak_reduce: assert property ( // R9
    limitMode && !auxAmpOff && state_reg == ST_RUN && auxOverS
      && peakCapLevel != '0 |=> peakCapLevel == $past(peakCapLevel) - 1'b1)
    else $error("peak limit not lowered");
  a_hiccup_entry: assert property ( // R10
    state_reg == ST_RUN && runOk && hiccupGo |=> state_reg == ST_HICCUP
      ##1 !converterRun)
    else $error("hiccup not entered after on-time");
  a_hiccup_off: assert property ( // R11
    state_reg == ST_HICCUP |-> rampDischarge && !converterRun)
    else $error("output on during hiccup");
  a_hiccup_exit: assert property ( // R12
    s_hiccup_done |=> s_restart)
    else $error("no soft-start after hiccup off-time");
  a_no_hiccup_ramp: assert property ( // R13
    state_reg != ST_RUN |-> onCnt_reg == '0)
    else $error("hiccup timing ran before ramp end");
  a_no_hiccup_mode: assert property ( // R14
    state_reg == ST_RUN && !hiccupEn && runOk |=> state_reg == ST_RUN)
    else $error("converter stopped without hiccup mode");
  a_fault_low: assert property ( // R15
    |faultClean |=> faultOutNOe && !faultOutNOut)
    else $error("fault pin not pulled low");
  a_fault_release: assert property ( // R16
    faultClean == '0 |=> !faultOutNOe)
    else $error("fault pin not released");
  a_thermal_stop: assert property ( // R18
    hotS |=> state_reg == ST_IDLE ##1 !converterRun)
    else $error("converter not stopped when hot");
  a_strap_hold: assert property ( // R21
    cfgValid_reg && $past(cfgValid_reg) |-> $stable(cfgLatched))
    else $error("strap selection changed while held");
endmodule
`default_nettype wire

//--- power_stage_model.sv
// Behavioural power stage: soft-start capacitor and pulled-up fault pin
`timescale 1ns/1ps
`default_nettype none
module power_stage_model #(
  parameter int RAMP_CYCLES = 30
)(
  input wire logic mclk, // Clock
  input wire logic rampCharge, // Ramp current source on
  input wire logic rampDischarge, // Ramp discharge switch on
  input wire logic faultOutNOut, // Fault pin drive value
  input wire logic faultOutNOe, // Fault pin pull-down enable
  output logic rampAboveRef, // Ramp above reference
  output logic faultOutNIn // Fault pin level
);
  int rampLevel = 0;
  always @(posedge mclk) begin
    if (rampDischarge) begin
      rampLevel <= 0;
    end else if (rampCharge && rampLevel < RAMP_CYCLES) begin
      rampLevel <= rampLevel + 1;
    end
  end
  assign rampAboveRef = (rampLevel >= RAMP_CYCLES);
  // Pull-up holds the pin high when released
  assign faultOutNIn = faultOutNOe ? faultOutNOut : 1'b1;
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the start-up and protection sequencer
`timescale 1ns/1ps
`default_nettype none
`include "buckboost_seq_map.svh"
module tb_top;
  import buckboost_seq_pkg::*;
  localparam int ON_C = 6;
  localparam int OFF_C = 40;
  logic mclk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, ack, trip;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat, rd;
  logic en = 0, vcc = 0, tied = 0, syncLevel = 1, syncValid = 0;
  logic aux = 0, peak = 0, hot = 0, pgFail = 0;
  logic [3:0] strap = 0;
  logic rampAbove, fIn, fOut, fOe, chg, dis, intRef, run, ampOff, neg;
  logic [7:0] cap;
  logic [3:0] cfgL;
  logic over_temperature_stop;
  int n_fail = 0, comparisons = 0;
  always #2 mclk = ~mclk;
  buckboost_startup_protection_seq #(.HICCUP_ON_CYCLES(ON_C),
    .HICCUP_OFF_CYCLES(OFF_C), .DEGLITCH_CYCLES(3), .PEAK_W(8)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .ce(1'b1), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .ack_o(ack),
    .dat_o(rdat), .enableUndervoltageInput(en), .vccOk(vcc),
    .rampAboveRef(rampAbove), .currentMonitorTied(tied),
    .syncLevel(syncLevel), .syncValid(syncValid), .auxSenseOverRef(aux),
    .peakSenseLimit(peak), .overTempHigh(hot), .powerGoodFail(pgFail),
    .cfgStrap(strap), .faultOutNIn(fIn), .faultOutNOut(fOut),
    .faultOutNOe(fOe), .rampCharge(chg), .rampDischarge(dis),
    .useInternalRef(intRef), .converterRun(run), .auxAmpOff(ampOff),
    .negCurrentLimit(neg), .peakCapLevel(cap), .overcurrentTrip(trip),
    .overTemperatureStop(over_temperature_stop), .cfgLatched(cfgL));
  power_stage_model ps_u (.mclk(mclk), .rampCharge(chg),
    .rampDischarge(dis), .faultOutNOut(fOut), .faultOutNOe(fOe),
    .rampAboveRef(rampAbove), .faultOutNIn(fIn));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 0; stb <= 0; we <= 0;
    if (n >= 50) check(0, 1);
  endtask
  task automatic waitState(input seq_state_t st);
    int n;
    n = 0;
    do begin
      wb(0, `BBS_ADDR_STATUS, 0, rd);
      n++;
    end while (rd[1:0] !== st && n < 100);
    check(rd[1:0], st);
  endtask
  task automatic startUp(input logic t, input logic s, input logic [3:0] c);
    @(posedge mclk);
    strap <= c; tied <= t; syncLevel <= s; en <= 1;
    waitState(ST_RAMP);
    check({chg, run, intRef}, 3'b110);
    waitState(ST_RUN);
    check(intRef, 1);
    check(rd[3:2], {~s, t});
    check({neg, ampOff}, {~s, t});
    check(cfgL, c);
  endtask
  task automatic shutDown();
    @(posedge mclk);
    en <= 0;
    waitState(ST_IDLE);
    check({dis, run}, 2'b10);
  endtask
  task automatic regsAtReset();
    wb(0, `BBS_ADDR_CTRL, 0, rd);
    check(rd, 32'h1);
    wb(0, `BBS_ADDR_PEAKCAP, 0, rd);
    check(rd, 32'hff);
    wb(0, 8'h20, 0, rd);
    check(rd, 32'h0);
  endtask
  task automatic noHiccup();
    startUp(1, 0, 4'h4);
    @(posedge mclk);
    peak <= 1;
    strap <= 4'h0;
    repeat (4 * ON_C) @(posedge mclk);
    check(run, 1);
    check(cfgL, 4'h4);
    peak <= 0;
    shutDown();
  endtask
  task automatic hiccup();
    int n;
    // monitor strap changed only while stopped
    startUp(0, 1, 4'h6);
    aux <= 1;
    repeat (20) @(posedge mclk);
    check(cap < 8'hff, 1);
    aux <= 0;
    peak <= 1;
    n = 0;
    while (trip !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    check(trip, 1);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (run !== 1'b1 && n < 200);
    check(n >= OFF_C && n <= OFF_C + 3, 1);
    waitState(ST_RAMP);
    waitState(ST_HICCUP);
    wb(0, `BBS_ADDR_EVENTS, 0, rd);
    check(rd[0], 1);
    peak <= 0;
    wb(1, `BBS_ADDR_EVENTS, 32'h7, rd);
    wb(0, `BBS_ADDR_EVENTS, 0, rd);
    check(rd[0], 0);
    waitState(ST_RUN);
  endtask
  task automatic thermal();
    @(posedge mclk);
    hot <= 1;
    waitState(ST_IDLE);
    check({run, dis}, 2'b01);
    repeat (8) @(posedge mclk);
    check(fIn, 0);
    check(over_temperature_stop, 1);
    wb(0, `BBS_ADDR_EVENTS, 0, rd);
    check(rd[2:1], 2'b11);
    hot <= 0;
    syncLevel <= 0;
    waitState(ST_RUN);
    check({over_temperature_stop, neg}, 2'b01);
    repeat (8) @(posedge mclk);
    check(fIn, 1);
    wb(1, `BBS_ADDR_CTRL, 32'h0, rd);
    waitState(ST_IDLE);
    check(run, 0);
    syncValid <= 1;
    wb(1, `BBS_ADDR_CTRL, 32'h1, rd);
    waitState(ST_RUN);
    check(neg, 0);
  endtask
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1;
    vcc <= 1;
    regsAtReset();
    noHiccup();
    hiccup();
    thermal();
    end_sim();
  end
endmodule
`default_nettype wire
